// [design/delay_counter.sv]
// Down counter that raises a one-cycle done pulse the loaded number of cycles after start.
// Assumes start is a one-cycle pulse in the sys_clk domain.
`timescale 1ns/100ps
`default_nettype none
module delay_counter #(
    parameter int WIDTH = 8
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic start,
    input wire logic [WIDTH-1:0] load,
    output logic busy,
    output logic done
);

    typedef struct packed {
        logic [WIDTH-1:0] count;
        logic run;
        logic fin;
    } cnt_s;

    cnt_s st_reg;
    cnt_s st_next;

    // Load on start, count down, raise done for one cycle at expiry.
    always_comb begin
        st_next = st_reg;
        st_next.fin = 1'b0;
        if (start) begin
            st_next.count = load;
            st_next.run = 1'b1;
        end else if (st_reg.run) begin
            if (st_reg.count <= {{(WIDTH-1){1'b0}}, 1'b1}) begin
                st_next.run = 1'b0;
                st_next.fin = 1'b1;
            end else begin
                st_next.count = st_reg.count - {{(WIDTH-1){1'b0}}, 1'b1};
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign busy = st_reg.run;
    assign done = st_reg.fin;

endmodule : delay_counter
`default_nettype wire

// [design/pm_seq_pkg.sv]
// Shared constants and types for the power mode clock sequencer.
// Assumes a single 50 MHz system clock and a synchronous active-low reset.
package pm_seq_pkg;

    // Clock source select encodings.
    localparam logic [1:0] SEL_PRIMARY = 2'h2;
    localparam logic [1:0] SEL_SECONDARY = 2'h1;
    localparam logic [1:0] SEL_INTERNAL = 2'h3;
    localparam logic [1:0] SEL_INTERNAL_ALT = 2'h0;

    // Register offsets on the plain register port.
    localparam logic [3:0] ADDR_CONTROL = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h1;
    localparam logic [3:0] ADDR_ENABLES = 4'h2;

    // Control register fields.
    localparam int CTRL_SEL_LSB = 0;
    localparam int CTRL_IDLE_BIT = 7;

    // Enable register fields.
    localparam int EN_SEC_OSC_BIT = 0;
    localparam int EN_WDT_BIT = 1;
    localparam int EN_FSCM_BIT = 2;
    localparam int EN_TWO_SPEED_BIT = 3;

    // Status register flag positions.
    localparam int STAT_SECONDARY_RUN_MODE_BIT = 6;
    localparam int STAT_INTERNAL_BIT = 5;

    // Clock source identifiers driven on the mux select.
    localparam logic [1:0] SRC_NONE = 2'h0;
    localparam logic [1:0] SRC_PRIMARY = 2'h1;
    localparam logic [1:0] SRC_SECONDARY = 2'h2;
    localparam logic [1:0] SRC_INTERNAL = 2'h3;

    // Switch timing in clock cycles of the old and new source.
    localparam logic [2:0] SWITCH_OLD_CYCLES = 3'h2;
    localparam logic [2:0] SWITCH_NEW_CYCLES = 3'h4;

    // CPU ready delay in nanoseconds and its cycle count at 50 MHz.
    localparam int CLK_PERIOD_NS = 20;
    localparam int CPU_READY_NS = 200;
    localparam int CPU_READY_CYCLES = (CPU_READY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Power mode states.
    typedef enum logic [3:0] {
        ST_PRIMARY_RUN_MODE,
        ST_SECONDARY_RUN_MODE,
        ST_MODE_A,
        ST_PRIMARY_IDLE_MODE,
        ST_SECONDARY_IDLE_MODE,
        ST_MODE_B,
        ST_SLEEP,
        ST_SWITCH,
        ST_WAKE_WAIT
    } mode_e;

endpackage : pm_seq_pkg

// [design/power_mode_clock_sequencer.sv]
// Power mode and clock source sequencer: run, idle and sleep modes with wake handling.
// Assumes oscillator ready levels and the sleep and wake pulses are synchronous to sys_clk.
//
// The implementer's own choices: the strobed register port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module power_mode_clock_sequencer #(
    parameter bit TWO_SPEED_DEFAULT = 1'b0
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic [3:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [7:0] regRdata,
    input wire logic sleepExec,
    input wire logic wakeIrq,
    input wire logic wdtTimeout,
    input wire logic primaryReady,
    input wire logic secondaryReady,
    output logic primaryOscOn,
    output logic secondaryOscOn,
    output logic internalOscOn,
    output logic [1:0] periphClkSrc,
    output logic cpuClkEn,
    output logic periphClkEn
);

    ////////////////////////////////////////////////////////////////////////////
    // State.

    typedef struct packed {
        pm_seq_pkg::mode_e mode;
        pm_seq_pkg::mode_e target;
        logic [1:0] clockSel;
        logic idleEnable;
        logic secOscEnable;
        logic wdtEnable;
        logic fscmEnable;
        logic twoSpeed;
        logic primaryStatus;
        logic secondaryRunning;
        logic [1:0] src;
        logic [1:0] newSrc;
        logic [2:0] phase;
        logic cpuEn;
        logic perEn;
        logic waitReady;
        logic [7:0] rdata;
    } seq_s;

    seq_s st_reg;
    seq_s st_next;
    logic readyStart;
    logic readyBusy;
    logic readyDone;

    // Ready delay counter started on every wake event.
    delay_counter #(.WIDTH(8)) u_ready (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .start(readyStart),
        .load(8'(pm_seq_pkg::CPU_READY_CYCLES)),
        .busy(readyBusy),
        .done(readyDone)
    );

    // Decoded selection helpers.
    function automatic logic isInternal(input logic [1:0] sel);
        isInternal = (sel == pm_seq_pkg::SEL_INTERNAL) || (sel == pm_seq_pkg::SEL_INTERNAL_ALT);
    endfunction : isInternal

    function automatic pm_seq_pkg::mode_e runOf(input logic [1:0] sel);
        if (sel == pm_seq_pkg::SEL_PRIMARY) begin
            runOf = pm_seq_pkg::ST_PRIMARY_RUN_MODE;
        end else if (sel == pm_seq_pkg::SEL_SECONDARY) begin
            runOf = pm_seq_pkg::ST_SECONDARY_RUN_MODE;
        end else begin
            runOf = pm_seq_pkg::ST_MODE_A;
        end
    endfunction : runOf

    function automatic logic [1:0] srcOf(input logic [1:0] sel);
        if (sel == pm_seq_pkg::SEL_PRIMARY) begin
            srcOf = pm_seq_pkg::SRC_PRIMARY;
        end else if (sel == pm_seq_pkg::SEL_SECONDARY) begin
            srcOf = pm_seq_pkg::SRC_SECONDARY;
        end else begin
            srcOf = pm_seq_pkg::SRC_INTERNAL;
        end
    endfunction : srcOf

    logic inIdle;
    logic inSleep;
    logic inRun;
    logic wakeEvent;
    logic [1:0] wrSel;

    assign inIdle = (st_reg.mode == pm_seq_pkg::ST_PRIMARY_IDLE_MODE) ||
                    (st_reg.mode == pm_seq_pkg::ST_SECONDARY_IDLE_MODE) ||
                    (st_reg.mode == pm_seq_pkg::ST_MODE_B);
    assign inSleep = (st_reg.mode == pm_seq_pkg::ST_SLEEP);
    assign inRun = (st_reg.mode == pm_seq_pkg::ST_PRIMARY_RUN_MODE) ||
                   (st_reg.mode == pm_seq_pkg::ST_SECONDARY_RUN_MODE) ||
                   (st_reg.mode == pm_seq_pkg::ST_MODE_A);
    // Only interrupt and watchdog wake; reset is handled by resetn itself.
    assign wakeEvent = (inIdle || inSleep) && (wakeIrq || wdtTimeout);
    assign wrSel = regWdata[pm_seq_pkg::CTRL_SEL_LSB +: 2];
    assign readyStart = wakeEvent;

    ////////////////////////////////////////////////////////////////////////////
    // Next state.

    // A clock switch runs through ST_SWITCH: the old source clocks at least three cycles, then
    // the new one clocks three cycles before the flags settle.
    always_comb begin
        st_next = st_reg;
        st_next.rdata = 8'h00;
        // Register writes only touch software fields, never from a switch or wake.
        if (regWr && regAddr == pm_seq_pkg::ADDR_CONTROL) begin
            st_next.clockSel = wrSel;
            st_next.idleEnable = regWdata[pm_seq_pkg::CTRL_IDLE_BIT];
        end else if (regWr && regAddr == pm_seq_pkg::ADDR_ENABLES) begin
            st_next.secOscEnable = regWdata[pm_seq_pkg::EN_SEC_OSC_BIT];
            st_next.wdtEnable = regWdata[pm_seq_pkg::EN_WDT_BIT];
            st_next.fscmEnable = regWdata[pm_seq_pkg::EN_FSCM_BIT];
            st_next.twoSpeed = regWdata[pm_seq_pkg::EN_TWO_SPEED_BIT];
        end
        if (regRd && regAddr == pm_seq_pkg::ADDR_CONTROL) begin
            st_next.rdata = {st_reg.idleEnable, 3'h0, st_reg.primaryStatus, 1'b0, st_reg.clockSel};
        end else if (regRd && regAddr == pm_seq_pkg::ADDR_STATUS) begin
            st_next.rdata = {4'h0, st_reg.mode};
            st_next.rdata[pm_seq_pkg::STAT_SECONDARY_RUN_MODE_BIT] = st_reg.secondaryRunning;
            st_next.rdata[pm_seq_pkg::STAT_INTERNAL_BIT] = !st_reg.primaryStatus &&
                                                           !st_reg.secondaryRunning;
        end else if (regRd && regAddr == pm_seq_pkg::ADDR_ENABLES) begin
            st_next.rdata = {4'h0, st_reg.twoSpeed, st_reg.fscmEnable, st_reg.wdtEnable,
                             st_reg.secOscEnable};
        end
        case (st_reg.mode)
            pm_seq_pkg::ST_PRIMARY_RUN_MODE, pm_seq_pkg::ST_SECONDARY_RUN_MODE, pm_seq_pkg::ST_MODE_A: begin
                if (sleepExec && !st_reg.idleEnable) begin
                    st_next.mode = pm_seq_pkg::ST_SLEEP;
                    st_next.cpuEn = 1'b0;
                    st_next.perEn = 1'b0;
                    st_next.primaryStatus = 1'b0;
                    st_next.secondaryRunning = 1'b0;
                end else if (sleepExec && st_reg.clockSel == pm_seq_pkg::SEL_SECONDARY &&
                             !st_reg.secOscEnable) begin
                    st_next.mode = st_reg.mode;
                end else if (sleepExec && st_reg.src == srcOf(st_reg.clockSel)) begin
                    st_next.mode = (st_reg.mode == pm_seq_pkg::ST_PRIMARY_RUN_MODE) ?
                                   pm_seq_pkg::ST_PRIMARY_IDLE_MODE :
                                   (st_reg.mode == pm_seq_pkg::ST_SECONDARY_RUN_MODE) ?
                                   pm_seq_pkg::ST_SECONDARY_IDLE_MODE : pm_seq_pkg::ST_MODE_B;
                    st_next.cpuEn = 1'b0;
                end else if (st_reg.src != srcOf(st_reg.clockSel) &&
                             !(st_reg.clockSel == pm_seq_pkg::SEL_SECONDARY &&
                               !st_reg.secOscEnable)) begin
                    st_next.mode = pm_seq_pkg::ST_SWITCH;
                    st_next.target = sleepExec ? pm_seq_pkg::ST_SLEEP : runOf(st_reg.clockSel);
                    if (sleepExec) begin
                        st_next.target = isInternal(st_reg.clockSel) ? pm_seq_pkg::ST_MODE_B :
                            (st_reg.clockSel == pm_seq_pkg::SEL_SECONDARY) ?
                            pm_seq_pkg::ST_SECONDARY_IDLE_MODE : pm_seq_pkg::ST_PRIMARY_IDLE_MODE;
                    end
                    st_next.newSrc = srcOf(st_reg.clockSel);
                    st_next.phase = 3'h0;
                end
            end
            pm_seq_pkg::ST_SWITCH: begin
                // Old source keeps clocking until a new primary is ready; a secondary not yet ready gates both CPU and peripheral clocks.
                if (st_reg.phase < pm_seq_pkg::SWITCH_OLD_CYCLES) begin
                    st_next.phase = st_reg.phase + 3'h1;
                end else if (st_reg.newSrc == pm_seq_pkg::SRC_PRIMARY && !primaryReady) begin
                    st_next.phase = st_reg.phase;
                end else if (st_reg.newSrc == pm_seq_pkg::SRC_SECONDARY && !secondaryReady) begin
                    st_next.perEn = 1'b0;
                    st_next.cpuEn = 1'b0;
                end else if (st_reg.phase < pm_seq_pkg::SWITCH_OLD_CYCLES +
                             pm_seq_pkg::SWITCH_NEW_CYCLES - 3'h1) begin
                    st_next.src = st_reg.newSrc;
                    st_next.perEn = 1'b1;
                    st_next.phase = st_reg.phase + 3'h1;
                end else begin
                    st_next.mode = st_reg.target;
                    st_next.cpuEn = (st_reg.target == pm_seq_pkg::ST_PRIMARY_RUN_MODE) ||
                                    (st_reg.target == pm_seq_pkg::ST_SECONDARY_RUN_MODE) ||
                                    (st_reg.target == pm_seq_pkg::ST_MODE_A);
                    st_next.primaryStatus = (st_reg.newSrc == pm_seq_pkg::SRC_PRIMARY);
                    st_next.secondaryRunning = (st_reg.newSrc == pm_seq_pkg::SRC_SECONDARY);
                end
            end
            pm_seq_pkg::ST_PRIMARY_IDLE_MODE, pm_seq_pkg::ST_SECONDARY_IDLE_MODE, pm_seq_pkg::ST_MODE_B: begin
                if (wakeEvent) begin
                    st_next.mode = pm_seq_pkg::ST_WAKE_WAIT;
                    // Interrupt wake returns to the run mode of the idle clock; watchdog wake to the run mode of clockSel.
                    st_next.target = (st_reg.mode == pm_seq_pkg::ST_PRIMARY_IDLE_MODE) ?
                        pm_seq_pkg::ST_PRIMARY_RUN_MODE : (st_reg.mode == pm_seq_pkg::ST_SECONDARY_IDLE_MODE) ?
                        pm_seq_pkg::ST_SECONDARY_RUN_MODE : pm_seq_pkg::ST_MODE_A;
                    if (wdtTimeout) begin
                        st_next.target = runOf(st_reg.clockSel);
                    end
                end
            end
            pm_seq_pkg::ST_SLEEP: begin
                st_next.src = pm_seq_pkg::SRC_NONE;
                if (wakeEvent) begin
                    st_next.mode = pm_seq_pkg::ST_WAKE_WAIT;
                    st_next.target = runOf(st_reg.clockSel);
                    st_next.waitReady = 1'b1;
                    if (st_reg.twoSpeed || st_reg.fscmEnable) begin
                        st_next.src = pm_seq_pkg::SRC_INTERNAL;
                        st_next.perEn = 1'b1;
                    end
                end
            end
            pm_seq_pkg::ST_WAKE_WAIT: begin
                if (st_reg.waitReady &&
                    ((srcOf(st_reg.clockSel) == pm_seq_pkg::SRC_PRIMARY && primaryReady) ||
                     (srcOf(st_reg.clockSel) == pm_seq_pkg::SRC_SECONDARY && secondaryReady) ||
                     srcOf(st_reg.clockSel) == pm_seq_pkg::SRC_INTERNAL)) begin
                    st_next.waitReady = 1'b0;
                    st_next.src = srcOf(st_reg.clockSel);
                    st_next.perEn = 1'b1;
                    st_next.primaryStatus = (srcOf(st_reg.clockSel) == pm_seq_pkg::SRC_PRIMARY);
                    st_next.secondaryRunning = (srcOf(st_reg.clockSel) == pm_seq_pkg::SRC_SECONDARY);
                end
                if (!st_reg.waitReady && !readyBusy) begin
                    st_next.mode = st_reg.target;
                    st_next.cpuEn = 1'b1;
                end
            end
            default: begin
                st_next.mode = pm_seq_pkg::ST_PRIMARY_RUN_MODE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers.

    // Reset lands in primary run; two-speed start brings it up on the internal clock.
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            st_reg <= '0;
            st_reg.mode <= TWO_SPEED_DEFAULT ? pm_seq_pkg::ST_MODE_A : pm_seq_pkg::ST_PRIMARY_RUN_MODE;
            st_reg.clockSel <= pm_seq_pkg::SEL_PRIMARY;
            st_reg.twoSpeed <= TWO_SPEED_DEFAULT;
            st_reg.primaryStatus <= !TWO_SPEED_DEFAULT;
            st_reg.src <= TWO_SPEED_DEFAULT ? pm_seq_pkg::SRC_INTERNAL : pm_seq_pkg::SRC_PRIMARY;
            st_reg.cpuEn <= 1'b1;
            st_reg.perEn <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs.

    // Primary stays on only while it is the clock, the target of a switch, or the selected clock in ST_WAKE_WAIT.
    assign primaryOscOn = (st_reg.src == pm_seq_pkg::SRC_PRIMARY &&
                           st_reg.mode != pm_seq_pkg::ST_SLEEP) ||
                          (st_reg.newSrc == pm_seq_pkg::SRC_PRIMARY &&
                           st_reg.mode == pm_seq_pkg::ST_SWITCH) ||
                          (st_reg.mode == pm_seq_pkg::ST_WAKE_WAIT &&
                           srcOf(st_reg.clockSel) == pm_seq_pkg::SRC_PRIMARY);
    assign secondaryOscOn = st_reg.secOscEnable;
    assign internalOscOn = st_reg.wdtEnable || st_reg.fscmEnable ||
                           (st_reg.src == pm_seq_pkg::SRC_INTERNAL);
    assign periphClkSrc = st_reg.src;
    assign cpuClkEn = st_reg.cpuEn;
    assign periphClkEn = st_reg.perEn;
    assign regRdata = st_reg.rdata;

    ////////////////////////////////////////////////////////////////////////////
    // Checks.

    chk_sleep_flags: assert property (@(posedge sys_clk) disable iff (!resetn)
        (inRun && sleepExec && !st_reg.idleEnable) |=>
        (!st_reg.primaryStatus && !st_reg.secondaryRunning && !cpuClkEn))
        else $error("Sleep left a status flag or CPU clock on.");

    chk_idle_cpu_off: assert property (@(posedge sys_clk) disable iff (!resetn)
        inIdle |-> (!cpuClkEn && periphClkEn))
        else $error("Idle mode must gate only the CPU clock.");

    chk_rc_kept: assert property (@(posedge sys_clk) disable iff (!resetn)
        (st_reg.wdtEnable || st_reg.fscmEnable) |-> internalOscOn)
        else $error("Internal oscillator stopped while needed.");

    sequence wakeSeq;
        inIdle && wakeIrq;
    endsequence

    chk_ready_delay: assert property (@(posedge sys_clk) disable iff (!resetn)
        wakeSeq |=> !cpuClkEn [*2])
        else $error("CPU clock released before ready delay.");

    chk_wake_bound: assert property (@(posedge sys_clk) disable iff (!resetn)
        wakeSeq |-> ##[1:20] cpuClkEn)
        else $error("CPU not released after idle wake.");

    // The counter's expiry pulse must hand the clock back on the very next edge.
    chk_ready_done: assert property (@(posedge sys_clk) disable iff (!resetn)
        (st_reg.mode == pm_seq_pkg::ST_WAKE_WAIT && !st_reg.waitReady && readyDone) |=>
        cpuClkEn)
        else $error("CPU clock not released when the ready delay expired.");

    chk_sel_stable: assert property (@(posedge sys_clk) disable iff (!resetn)
        !regWr |=> $stable(st_reg.clockSel) && $stable(st_reg.idleEnable))
        else $error("Select bits changed without a write.");

    chk_sec_refused: assert property (@(posedge sys_clk) disable iff (!resetn)
        (st_reg.mode == pm_seq_pkg::ST_SECONDARY_RUN_MODE) |-> st_reg.secOscEnable || st_reg.secondaryRunning)
        else $error("Secondary run entered without oscillator enable.");

    chk_primary_idle_mode_flag: assert property (@(posedge sys_clk) disable iff (!resetn)
        (st_reg.mode == pm_seq_pkg::ST_PRIMARY_IDLE_MODE) |-> (st_reg.primaryStatus && primaryOscOn))
        else $error("Primary idle lost its clock or status.");

endmodule : power_mode_clock_sequencer
`default_nettype wire

// [verif/osc_model.sv]
// Oscillator model for the far side: ready levels that trail the enables.
// Assumes the enables come from the sequencer in the sys_clk domain.
`timescale 1ns/100ps
`default_nettype none
module osc_model #(
    parameter int START = 6
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic primaryOscOn,
    input wire logic secondaryOscOn,
    output logic primaryReady,
    output logic secondaryReady
);
    logic [3:0] pCnt;
    logic [3:0] sCnt;
    // Ready drops on the next edge when an oscillator stops and returns only after
    // START cycles, so no switch may count on a warm source.
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            pCnt <= 4'(START);
            sCnt <= 4'h0;
        end else begin
            pCnt <= !primaryOscOn ? 4'h0 : (pCnt == 4'(START) ? pCnt : pCnt + 4'h1);
            sCnt <= !secondaryOscOn ? 4'h0 : (sCnt == 4'(START) ? sCnt : sCnt + 4'h1);
        end
    end
    assign primaryReady = (pCnt == 4'(START));
    assign secondaryReady = (sCnt == 4'(START));
endmodule : osc_model
`default_nettype wire

// [verif/tb.sv]
// Testbench for the power mode clock sequencer.
// Assumes the oscillator model on the far side and the package constants.
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic [3:0] regAddr = 4'h0;
    logic [7:0] regWdata = 8'h00;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic sleepExec = 1'b0;
    logic wakeIrq = 1'b0;
    logic wdtTimeout = 1'b0;
    logic [7:0] regRdata;
    logic primaryReady, secondaryReady, primaryOscOn, secondaryOscOn, internalOscOn;
    logic [1:0] periphClkSrc;
    logic cpuClkEn, periphClkEn, rdSeen;
    logic [7:0] expQ[$];
    int bad_count = 0;
    int tests_run = 0;
    int n;
    always #10 sys_clk = ~sys_clk;
    power_mode_clock_sequencer dut (.sys_clk(sys_clk), .resetn(resetn), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
        .sleepExec(sleepExec), .wakeIrq(wakeIrq), .wdtTimeout(wdtTimeout),
        .primaryReady(primaryReady), .secondaryReady(secondaryReady),
        .primaryOscOn(primaryOscOn), .secondaryOscOn(secondaryOscOn),
        .internalOscOn(internalOscOn), .periphClkSrc(periphClkSrc),
        .cpuClkEn(cpuClkEn), .periphClkEn(periphClkEn));
    osc_model osc (.sys_clk(sys_clk), .resetn(resetn), .primaryOscOn(primaryOscOn),
        .secondaryOscOn(secondaryOscOn), .primaryReady(primaryReady),
        .secondaryReady(secondaryReady));
    ////////////////////////////////////////////////////////////////////////
    // Compares one value and counts the outcome.
    task check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
            bad_count++;
        end
    endtask : check
    task final_report;
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : final_report
    // One-cycle register write and read; the read notes its expected data.
    task wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge sys_clk);
        regWr <= 1'b0;
    endtask : wr
    task rd(input logic [3:0] a, input logic [7:0] exp);
        expQ.push_back(exp);
        @(posedge sys_clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge sys_clk);
        regRd <= 1'b0;
        @(posedge sys_clk);
    endtask : rd
    // Pulses sleep, interrupt or watchdog as {sleep, irq, watchdog}.
    task pulse(input logic [2:0] w);
        @(posedge sys_clk);
        {sleepExec, wakeIrq, wdtTimeout} <= w;
        @(posedge sys_clk);
        {sleepExec, wakeIrq, wdtTimeout} <= 3'h0;
    endtask : pulse
    // Bounded waits, since a switch length depends on oscillator start-up.
    // Outputs are looked at on the falling edge, where they have settled.
    task waitSrc(input logic [1:0] s);
        n = 0;
        while (periphClkSrc !== s && n < 60) begin
            @(negedge sys_clk);
            n++;
        end
        check(8'(periphClkSrc), 8'(s));
    endtask : waitSrc
    task waitCpu;
        n = 0;
        while (cpuClkEn !== 1'b1 && n < 100) begin
            @(negedge sys_clk);
            n++;
        end
        check(8'(cpuClkEn), 8'h01);
    endtask : waitCpu
    // Read data stand only in the cycle after the strobe; compare there.
    always @(posedge sys_clk) begin
        if (rdSeen === 1'b1) check(regRdata, expQ.pop_front());
        rdSeen <= regRd;
    end
    initial begin
        #200000;
        bad_count++;
        final_report();
    end
    initial begin
        void'($urandom(32'h142daf2d));
        repeat (4) @(posedge sys_clk);
        resetn <= 1'b1;
        rd(pm_seq_pkg::ADDR_CONTROL, 8'h0A);
        check(8'(periphClkSrc), 8'(pm_seq_pkg::SRC_PRIMARY));
        $display("test reset done");
        wr(pm_seq_pkg::ADDR_CONTROL, 8'h01);
        repeat (12) @(posedge sys_clk);
        check(8'(periphClkSrc), 8'(pm_seq_pkg::SRC_PRIMARY));
        $display("test refused switch done");
        wr(pm_seq_pkg::ADDR_ENABLES, 8'h03);
        @(negedge sys_clk);
        check(8'(internalOscOn), 8'h01);
        wr(pm_seq_pkg::ADDR_CONTROL, 8'h01);
        waitSrc(pm_seq_pkg::SRC_SECONDARY);
        repeat (4) @(posedge sys_clk);
        check(8'(primaryOscOn), 8'h00);
        rd(pm_seq_pkg::ADDR_STATUS, 8'h41);
        rd(pm_seq_pkg::ADDR_CONTROL, 8'h01);
        wr(pm_seq_pkg::ADDR_CONTROL, 8'h02);
        waitSrc(pm_seq_pkg::SRC_PRIMARY);
        repeat (4) @(posedge sys_clk);
        check(8'(secondaryOscOn), 8'h01);
        rd(pm_seq_pkg::ADDR_CONTROL, 8'h0A);
        $display("test secondary run done");
        wr(pm_seq_pkg::ADDR_CONTROL, 8'h82 | (8'($urandom) & 8'h74));
        pulse(3'h4);
        repeat (4) @(posedge sys_clk);
        check({6'h0, cpuClkEn, periphClkEn}, 8'h01);
        repeat ($urandom_range(5, 1)) @(posedge sys_clk);
        pulse(3'h2);
        waitCpu();
        check(8'(n + 1 >= pm_seq_pkg::CPU_READY_CYCLES), 8'h01);
        check(8'(periphClkSrc), 8'(pm_seq_pkg::SRC_PRIMARY));
        rd(pm_seq_pkg::ADDR_CONTROL, 8'h8A);
        $display("test primary idle done");
        wr(pm_seq_pkg::ADDR_CONTROL, 8'h02);
        pulse(3'h4);
        repeat (4) @(posedge sys_clk);
        check({5'h0, periphClkEn, primaryOscOn, cpuClkEn}, 8'h00);
        check({6'h0, internalOscOn, secondaryOscOn}, 8'h03);
        repeat ($urandom_range(5, 1)) @(posedge sys_clk);
        pulse(3'h1);
        waitCpu();
        check(8'(cpuClkEn), 8'h01);
        check(8'(periphClkSrc), 8'(pm_seq_pkg::SRC_PRIMARY));
        rd(pm_seq_pkg::ADDR_CONTROL, 8'h0A);
        $display("test sleep done");
        wr(pm_seq_pkg::ADDR_CONTROL, 8'h03);
        waitSrc(pm_seq_pkg::SRC_INTERNAL);
        repeat (4) @(posedge sys_clk);
        check(8'(primaryOscOn), 8'h00);
        rd(pm_seq_pkg::ADDR_STATUS, 8'h22);
        $display("test internal run done");
        wr(pm_seq_pkg::ADDR_ENABLES, 8'h02);
        wr(pm_seq_pkg::ADDR_CONTROL, 8'h81);
        pulse(3'h4);
        rd(pm_seq_pkg::ADDR_STATUS, 8'h22);
        check(8'(cpuClkEn), 8'h01);
        wr(pm_seq_pkg::ADDR_ENABLES, 8'h03);
        repeat (5) @(posedge sys_clk);
        check({6'h0, cpuClkEn, periphClkEn}, 8'h00);
        waitSrc(pm_seq_pkg::SRC_SECONDARY);
        repeat (4) @(posedge sys_clk);
        pulse(3'h4);
        rd(pm_seq_pkg::ADDR_STATUS, 8'h44);
        check({6'h0, primaryOscOn, cpuClkEn}, 8'h00);
        pulse(3'h2);
        waitCpu();
        check(8'(n + 1 >= pm_seq_pkg::CPU_READY_CYCLES), 8'h01);
        check(8'(periphClkSrc), 8'(pm_seq_pkg::SRC_SECONDARY));
        rd(pm_seq_pkg::ADDR_CONTROL, 8'h81);
        $display("test secondary idle done");
        wr(pm_seq_pkg::ADDR_CONTROL, 8'h83);
        waitSrc(pm_seq_pkg::SRC_INTERNAL);
        repeat (4) @(posedge sys_clk);
        pulse(3'h4);
        pulse(3'h2);
        waitCpu();
        check(8'(n + 1 >= pm_seq_pkg::CPU_READY_CYCLES), 8'h01);
        check(8'(periphClkSrc), 8'(pm_seq_pkg::SRC_INTERNAL));
        wr(pm_seq_pkg::ADDR_CONTROL, 8'h02);
        repeat (3) @(posedge sys_clk);
        check(8'(periphClkSrc), 8'(pm_seq_pkg::SRC_INTERNAL));
        waitSrc(pm_seq_pkg::SRC_PRIMARY);
        repeat (4) @(posedge sys_clk);
        rd(pm_seq_pkg::ADDR_CONTROL, 8'h0A);
        $display("test internal idle done");
        resetn <= 1'b0;
        repeat (4) @(posedge sys_clk);
        resetn <= 1'b1;
        rd(pm_seq_pkg::ADDR_CONTROL, 8'h0A);
        check(8'(periphClkSrc), 8'(pm_seq_pkg::SRC_PRIMARY));
        $display("test second reset done");
        final_report();
    end
endmodule : tb
`default_nettype wire
